/* File: rtl/gscc_cfg.svh */
// gauge serial command control: offsets, bit positions, reset values, timing counts
// assumes a 200 MHz system clock
`ifndef GSCC_CFG_SVH
`define GSCC_CFG_SVH
`define GSCC_CLK_HZ 200000000
`define GSCC_BAUD_LO 19200
`define GSCC_BAUD_HI 38400
`define GSCC_DIV_LO (`GSCC_CLK_HZ / `GSCC_BAUD_LO)
`define GSCC_DIV_HI (`GSCC_CLK_HZ / `GSCC_BAUD_HI)
`define GSCC_DEGAS_S 120
`define GSCC_DEGAS_CYC (64'(`GSCC_DEGAS_S) * 64'(`GSCC_CLK_HZ))
`define GSCC_BEAT_MS 500
`define GSCC_BEAT_CYC (`GSCC_BEAT_MS * (`GSCC_CLK_HZ / 1000))
`define GSCC_ADJ_CYC 1000
`define GSCC_CTRL_RESET 16'h0009
`define GSCC_B_AUTO 0
`define GSCC_B_THERM 1
`define GSCC_B_ION 2
`define GSCC_B_ACATH 3
`define GSCC_B_CAT1 4
`define GSCC_B_CAT2 5
`define GSCC_B_DEGAS 6
`define GSCC_B_LOWI 7
`define GSCC_B_SPMAN 8
`define GSCC_B_SPLVL 9
`define GSCC_B_SPPRS 10
`define GSCC_B_EXT 11
`define GSCC_B_ERR 12
`define GSCC_B_ZERO 13
`define GSCC_B_ATM 14
`define GSCC_B_BEAT 15
`define GSCC_CH_CR 8'h0d
`define GSCC_CH_US 8'h5f
`define GSCC_RBUF 12
`define GSCC_TBUF 16
`endif

/* File: rtl/gscc_pkg.sv */
// gauge serial command control: shared types
// assumes gscc_cfg.svh for numbers
`default_nettype none
package gscc_pkg;
  typedef struct packed {
    logic [7:0] mant_int;
    logic [7:0] mant_f1;
    logic [7:0] mant_f2;
    logic exp_neg;
    logic [7:0] exp_d1;
    logic [7:0] exp_d0;
  } gscc_press_t;
  typedef enum logic [1:0] {
    GSCC_IDLE = 2'b00,
    GSCC_EXEC = 2'b01,
    GSCC_SEND = 2'b10
  } gscc_state_t;
endpackage
`default_nettype wire

/* File: rtl/gscc_top.sv */
// gauge serial command control: uart framing, command parse, control and status words
// assumes synchronous rx line, pressure digits as ascii from the measuring front end
//
// What this block does
// R1: frames are 8 data bits, no parity, 1 stop, 19200 or 38400 baud.
// R2: commands and replies end with a carriage return.
// R3: read-pressure command returns status prefix then pressure value.
// R4: prefix P thermal, I1/I2 ion cathode, D degassing, E error.
// R5: pressure as mantissa, E, sign character, two exponent digits.
// R6: underscore separates command from argument and prefix from value.
// R7: control word arrives as four hex digits; 0009 means full auto.
// R8: bit 0 auto branch; bits 1,2 only when bit 0 clear.
// R9: bit 3 auto cathode; bits 4,5 manual only with thermal branch active; bit 5 alone, with bits 3,4 clear, is also taken with the ion branch active.
// R10: bit 6 starts degassing, ended automatically after 2 minutes.
// R11: bit 7 selects low ion emission current.
// R12: jumper one closed, bit 8 gives manual set-point, bit 9 level.
// R13: jumper one closed, bit 8 clear, bit 10 follows pressure condition.
// R14: bit 12 clears ion error, accepted only with bit 1 set, bit 0 clear.
// R15: bits 13, 14 start thermal vacuum zero and atmosphere adjustment.
// R16: 0021 gives auto branch with cathode two; 0049 starts degas.
// R17: status command returns 16-bit status as four hex digits.
// R18: status bits 1,2 branch-only; bits 3 to 7 mirror cathode, degas, emission.
// R19: status bit 9 shows set-point output level, 1 meaning 24 V.
// R20: status bit 10 set while set-point function or degas output active.
// R21: status bit 11 external control; bit 12 latched ion error.
// R22: status bits 13, 14 set while adjustments run.
// R23: status bit 15 toggles every 500 ms as heartbeat.
`include "gscc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module gscc_top import gscc_pkg::*; (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // serial link
  input wire logic rx_in,
  output logic tx_out,
  // configuration and front end
  input wire logic baud_high_in,
  input wire logic setpoint_jumper_one_in,
  input wire logic external_control_on_in,
  input wire logic ion_branch_active_in,
  input wire logic ion_error_in,
  input wire logic setpoint_pressure_met_in,
  input wire gscc_press_t pressure_in,
  // gauge controls
  output logic [15:0] gauge_control_out,
  output logic setpoint_output_level_out
);
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) hex_val = {1'b1, c[3:0]};
    else if ((c | 8'h20) >= 8'h61 && (c | 8'h20) <= 8'h66) hex_val = {1'b1, c[3:0] + 4'h9};
    else hex_val = 5'h00;
  endfunction

  // -----------------------------------------------------------------
  // baud timing
  // -----------------------------------------------------------------
  logic [15:0] div_w;
  assign div_w = baud_high_in ? 16'(`GSCC_DIV_HI) : 16'(`GSCC_DIV_LO); // [R1]

  // -----------------------------------------------------------------
  // receiver
  // -----------------------------------------------------------------
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_busy_q;
  logic rx_stb_q;
  always_ff @(posedge sys_clk_in) begin
    rx_stb_q <= 1'b0;
    if (!rst_n_in) begin
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_busy_q <= 1'b0;
    end else if (!rx_busy_q) begin
      if (!rx_in) begin
        rx_busy_q <= 1'b1;
        rx_cnt_q <= {1'b0, div_w[15:1]}; // sample mid-bit
        rx_bit_q <= 4'h0;
      end
    end else if (rx_cnt_q != 16'h0000) begin
      rx_cnt_q <= rx_cnt_q - 16'h0001;
    end else begin
      rx_cnt_q <= div_w - 16'h0001;
      rx_bit_q <= rx_bit_q + 4'h1;
      if (rx_bit_q == 4'h0 && rx_in) rx_busy_q <= 1'b0; // glitch, not a start bit
      else if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8) rx_sh_q <= {rx_in, rx_sh_q[7:1]}; // [R1]
      else if (rx_bit_q == 4'h9) begin
        rx_busy_q <= 1'b0;
        rx_stb_q <= rx_in; // framing error drops the byte
      end
    end
  end

  // -----------------------------------------------------------------
  // command line buffer
  // -----------------------------------------------------------------
  logic [7:0] line_q [`GSCC_RBUF];
  logic [3:0] len_q;
  logic line_done_q;
  gscc_state_t st_q;
  always_ff @(posedge sys_clk_in) begin
    line_done_q <= 1'b0;
    if (!rst_n_in) begin
      len_q <= 4'h0;
    end else if (rx_stb_q) begin
      if (rx_sh_q == `GSCC_CH_CR) begin // [R2]
        line_done_q <= (st_q == GSCC_IDLE);
      end else if (len_q < 4'(`GSCC_RBUF)) begin
        line_q[len_q] <= rx_sh_q;
        len_q <= len_q + 4'h1;
      end
    end else if (line_done_q) begin
      len_q <= 4'h0;
    end
  end

  // -----------------------------------------------------------------
  // command decode
  // -----------------------------------------------------------------
  logic is_rv, is_rs, is_sc;
  logic [15:0] arg_w;
  logic arg_ok;
  logic [4:0] h0, h1, h2, h3;
  assign is_rv = len_q == 4'h2 && line_q[0] == 8'h52 && line_q[1] == 8'h56;
  assign is_rs = len_q == 4'h2 && line_q[0] == 8'h52 && line_q[1] == 8'h53;
  assign h0 = hex_val(line_q[3]);
  assign h1 = hex_val(line_q[4]);
  assign h2 = hex_val(line_q[5]);
  assign h3 = hex_val(line_q[6]);
  assign arg_ok = h0[4] & h1[4] & h2[4] & h3[4];
  assign arg_w = {h0[3:0], h1[3:0], h2[3:0], h3[3:0]}; // [R7]
  assign is_sc = len_q == 4'h7 && line_q[0] == 8'h53 && line_q[1] == 8'h43
    && line_q[2] == `GSCC_CH_US && arg_ok; // [R6]

  // -----------------------------------------------------------------
  // control word
  // -----------------------------------------------------------------
  logic [15:0] ctrl_q;
  logic [35:0] degas_q;
  logic [15:0] zero_q, atm_q;
  logic err_q;
  logic degas_on, zero_on, atm_on;
  assign degas_on = degas_q != 36'h0;
  assign zero_on = zero_q != 16'h0;
  assign atm_on = atm_q != 16'h0;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ctrl_q <= `GSCC_CTRL_RESET;
    end else if (line_done_q && is_sc) begin
      ctrl_q <= arg_w;
      if (arg_w[`GSCC_B_AUTO]) ctrl_q[`GSCC_B_ION:`GSCC_B_THERM] <= 2'b00; // [R8]
      if (arg_w[`GSCC_B_ACATH] || ion_branch_active_in)
        ctrl_q[`GSCC_B_CAT2:`GSCC_B_CAT1] <= ctrl_q[`GSCC_B_CAT2:`GSCC_B_CAT1]; // [R9]
      else if (arg_w[`GSCC_B_CAT1] && arg_w[`GSCC_B_CAT2])
        ctrl_q[`GSCC_B_CAT2] <= 1'b0; // exclusive, cathode one wins [R9]
      if (!arg_w[`GSCC_B_ACATH] && !arg_w[`GSCC_B_CAT1] && arg_w[`GSCC_B_CAT2])
        ctrl_q[`GSCC_B_CAT2] <= 1'b1; // [R16]
      ctrl_q[`GSCC_B_DEGAS] <= 1'b0;
      ctrl_q[`GSCC_B_ERR] <= 1'b0;
      ctrl_q[`GSCC_B_ZERO] <= 1'b0;
      ctrl_q[`GSCC_B_ATM] <= 1'b0;
      ctrl_q[`GSCC_B_EXT] <= 1'b0;
      ctrl_q[`GSCC_B_BEAT] <= 1'b0;
    end
  end

  // degas and adjustment timers, one-shot on command
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      degas_q <= 36'h0;
      zero_q <= 16'h0;
      atm_q <= 16'h0;
    end else begin
      if (line_done_q && is_sc && arg_w[`GSCC_B_DEGAS]) degas_q <= 36'(`GSCC_DEGAS_CYC); // [R10]
      else if (degas_on) degas_q <= degas_q - 36'h1; // [R10]
      if (line_done_q && is_sc && arg_w[`GSCC_B_ZERO]) zero_q <= 16'(`GSCC_ADJ_CYC); // [R15]
      else if (zero_on) zero_q <= zero_q - 16'h1;
      if (line_done_q && is_sc && arg_w[`GSCC_B_ATM]) atm_q <= 16'(`GSCC_ADJ_CYC); // [R15]
      else if (atm_on) atm_q <= atm_q - 16'h1;
    end
  end

  // ion error latch: new error wins over clear
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) err_q <= 1'b0;
    else if (ion_error_in) err_q <= 1'b1; // [R21]
    else if (line_done_q && is_sc && arg_w[`GSCC_B_ERR] && ctrl_q[`GSCC_B_THERM]
      && !ctrl_q[`GSCC_B_AUTO]) err_q <= 1'b0; // [R14]
  end

  // set-point output
  logic sp_d;
  always_comb begin
    sp_d = 1'b0;
    if (setpoint_jumper_one_in) begin
      if (ctrl_q[`GSCC_B_SPMAN]) sp_d = ctrl_q[`GSCC_B_SPLVL]; // [R12]
      else if (ctrl_q[`GSCC_B_SPPRS]) sp_d = setpoint_pressure_met_in; // [R13]
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      setpoint_output_level_out <= 1'b0;
      gauge_control_out <= `GSCC_CTRL_RESET;
    end else begin
      setpoint_output_level_out <= sp_d;
      gauge_control_out <= {1'b0, atm_on, zero_on, 2'b00, ctrl_q[10:7], degas_on, ctrl_q[5:0]};
    end
  end

  // -----------------------------------------------------------------
  // heartbeat
  // -----------------------------------------------------------------
  logic [27:0] beat_cnt_q;
  logic beat_q;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      beat_cnt_q <= 28'h0;
      beat_q <= 1'b0;
    end else if (beat_cnt_q == 28'(`GSCC_BEAT_CYC - 1)) begin
      beat_cnt_q <= 28'h0;
      beat_q <= ~beat_q; // [R23]
    end else beat_cnt_q <= beat_cnt_q + 28'h1;
  end

  // -----------------------------------------------------------------
  // status word
  // -----------------------------------------------------------------
  logic [15:0] stat_w;
  assign stat_w = {beat_q, atm_on, zero_on, err_q, external_control_on_in, // [R21] [R22] [R23]
    ctrl_q[`GSCC_B_SPPRS] | degas_on, setpoint_output_level_out, // [R19] [R20]
    ctrl_q[`GSCC_B_SPMAN], ctrl_q[`GSCC_B_LOWI], degas_on, // [R11] [R18]
    ctrl_q[`GSCC_B_CAT2], // cathode one is in use unless two was chosen [R17]
    ctrl_q[`GSCC_B_CAT1] | ~ctrl_q[`GSCC_B_CAT2], ctrl_q[`GSCC_B_ACATH],
    ion_branch_active_in, ~ion_branch_active_in, ctrl_q[`GSCC_B_AUTO]}; // [R18]

  // -----------------------------------------------------------------
  // reply builder and transmitter
  // -----------------------------------------------------------------
  logic [7:0] tb_q [`GSCC_TBUF];
  logic [4:0] tlen_q, tidx_q;
  logic [15:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [9:0] tx_sh_q;
  logic [7:0] pfx0, pfx1;
  always_comb begin
    pfx1 = 8'h00;
    if (err_q) pfx0 = 8'h45; // [R4]
    else if (degas_on) pfx0 = 8'h44;
    else if (ion_branch_active_in) begin
      pfx0 = 8'h49;
      pfx1 = ctrl_q[`GSCC_B_CAT2] ? 8'h32 : 8'h31; // [R4]
    end else pfx0 = 8'h50;
  end
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_q <= GSCC_IDLE;
      tlen_q <= 5'h0;
      tidx_q <= 5'h0;
      tx_cnt_q <= 16'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 10'h3ff;
      tx_out <= 1'b1;
    end else begin
      tx_out <= tx_sh_q[0];
      case (st_q)
        GSCC_IDLE: begin
          if (line_done_q && is_rv) begin // [R3]
            tb_q[0] <= pfx0;
            if (pfx1 != 8'h00) begin
              tb_q[1] <= pfx1;
              tb_q[2] <= `GSCC_CH_US; // [R6]
              tb_q[3] <= pressure_in.mant_int; // [R5]
              tb_q[4] <= 8'h2e;
              tb_q[5] <= pressure_in.mant_f1;
              tb_q[6] <= pressure_in.mant_f2;
              tb_q[7] <= 8'h45;
              tb_q[8] <= pressure_in.exp_neg ? 8'h2d : 8'h2b;
              tb_q[9] <= pressure_in.exp_d1;
              tb_q[10] <= pressure_in.exp_d0;
              tb_q[11] <= `GSCC_CH_CR; // [R2]
              tlen_q <= 5'd12;
            end else begin
              tb_q[1] <= `GSCC_CH_US;
              tb_q[2] <= pressure_in.mant_int;
              tb_q[3] <= 8'h2e;
              tb_q[4] <= pressure_in.mant_f1;
              tb_q[5] <= pressure_in.mant_f2;
              tb_q[6] <= 8'h45;
              tb_q[7] <= pressure_in.exp_neg ? 8'h2d : 8'h2b; // [R5]
              tb_q[8] <= pressure_in.exp_d1;
              tb_q[9] <= pressure_in.exp_d0;
              tb_q[10] <= `GSCC_CH_CR;
              tlen_q <= 5'd11;
            end
            tidx_q <= 5'h0;
            st_q <= GSCC_SEND;
          end else if (line_done_q && is_rs) begin // [R17]
            tb_q[0] <= hex_char(stat_w[15:12]);
            tb_q[1] <= hex_char(stat_w[11:8]);
            tb_q[2] <= hex_char(stat_w[7:4]);
            tb_q[3] <= hex_char(stat_w[3:0]);
            tb_q[4] <= `GSCC_CH_CR; // [R2]
            tlen_q <= 5'd5;
            tidx_q <= 5'h0;
            st_q <= GSCC_SEND;
          end
        end
        GSCC_SEND: begin
          if (tx_bit_q == 4'h0) begin
            if (tidx_q == tlen_q) st_q <= GSCC_IDLE;
            else begin
              tx_sh_q <= {1'b1, tb_q[tidx_q[3:0]], 1'b0}; // [R1]
              tidx_q <= tidx_q + 5'h1;
              tx_bit_q <= 4'ha;
              tx_cnt_q <= div_w - 16'h1;
            end
          end else if (tx_cnt_q != 16'h0) tx_cnt_q <= tx_cnt_q - 16'h1;
          else begin
            tx_cnt_q <= div_w - 16'h1;
            tx_bit_q <= tx_bit_q - 4'h1;
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
          end
        end
        default: st_q <= GSCC_IDLE;
      endcase
    end
  end
endmodule // gscc_top
`default_nettype wire

/* File: test/gscc_top_chk.sv */
// gauge serial command control: port-level assertions
// assumes bound to gscc_top, cfg header on the include path
`include "gscc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module gscc_top_chk (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // watched ports
  input wire logic tx_out,
  input wire logic baud_high_in,
  input wire logic setpoint_jumper_one_in,
  input wire logic setpoint_pressure_met_in,
  input wire logic [15:0] gauge_control_out,
  input wire logic setpoint_output_level_out
);
  // ---------------------------------------------
  // low run counter, exact bit times show up here
  // ---------------------------------------------
  int unsigned low_q;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) low_q <= 0;
    else low_q <= tx_out ? 0 : low_q + 1;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // four stable samples so a pin synchroniser does not trip it
  sequence s_manual;
    setpoint_jumper_one_in && gauge_control_out[8] && $stable(gauge_control_out);
  endsequence
  sequence s_follow;
    setpoint_jumper_one_in && !gauge_control_out[8] && gauge_control_out[10] &&
      $stable(gauge_control_out) && $stable(setpoint_pressure_met_in);
  endsequence
  chk_reset_state_idle: assert property ($rose(rst_n_in) |-> tx_out &&
    gauge_control_out == 16'h0009 && !setpoint_output_level_out)
    else $error("tx or control word not idle after reset");
  chk_auto_branch_excl: assert property (gauge_control_out[0] |->
    gauge_control_out[2:1] == 2'b00) else $error("branch-only bits kept in auto mode");
  chk_cathode_one_hot: assert property ($onehot0(gauge_control_out[5:4]))
    else $error("both cathodes selected");
  chk_spare_bits_zero: assert property (gauge_control_out[15] == 1'b0 &&
    gauge_control_out[12:11] == 2'b00) else $error("unstored control bits set");
  chk_sp_manual_level: assert property (s_manual[*4] |->
    setpoint_output_level_out == gauge_control_out[9]) else $error("manual set-point wrong");
  chk_sp_follow_press: assert property (s_follow[*4] |->
    setpoint_output_level_out == setpoint_pressure_met_in) else $error("set-point not following");
  chk_tx_bit_time: assert property ($rose(tx_out) |->
    low_q % (baud_high_in ? `GSCC_DIV_HI : `GSCC_DIV_LO) == 0) else $error("tx low run off grid");
  chk_tx_low_max: assert property (low_q <= 9 * (baud_high_in ? `GSCC_DIV_HI : `GSCC_DIV_LO))
    else $error("tx low longer than a frame");
endmodule // gscc_top_chk
bind gscc_top gscc_top_chk u_gscc_top_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .tx_out(tx_out), .baud_high_in(baud_high_in), .setpoint_jumper_one_in(setpoint_jumper_one_in),
  .setpoint_pressure_met_in(setpoint_pressure_met_in), .gauge_control_out(gauge_control_out),
  .setpoint_output_level_out(setpoint_output_level_out));
`default_nettype wire

/* File: test/gscc_host_model.sv */
// gauge serial command control: host computer on the serial link
// assumes the device clock is visible, line idles high between frames
`include "gscc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module gscc_host_model (
  // clock and rate
  input wire logic sys_clk_in,
  input wire logic baud_high_in,
  // serial lines
  input wire logic line_from_dev_in,
  output logic line_to_dev_out
);
  int div;
  byte unsigned rxq[$];
  always_comb div = baud_high_in ? `GSCC_DIV_HI : `GSCC_DIV_LO;
  initial line_to_dev_out = 1'b1;
  // start, 8 data lsb first, one stop, no parity
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge sys_clk_in);
      line_to_dev_out = fr[i];
      repeat (div - 1) @(negedge sys_clk_in);
    end
  endtask
  // caller writes the underscore and hex digits into the string
  task automatic send_line(input string s);
    for (int i = 0; i < s.len(); i++) send_byte(s[i]);
    send_byte(8'h0d);
  endtask
  // receiver samples mid-bit; runs free so replies overlap our stop bit
  always begin
    logic [7:0] d;
    @(negedge line_from_dev_in);
    repeat (div / 2) @(posedge sys_clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge sys_clk_in);
      d[i] = line_from_dev_in;
    end
    repeat (div) @(posedge sys_clk_in);
    rxq.push_back(d);
  end
endmodule // gscc_host_model
`default_nettype wire

/* File: test/gscc_top_tb.sv */
// gauge serial command control: self-checking bench
// assumes host model on the link, checker bound to the top
`include "gscc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module gscc_top_tb import gscc_pkg::*;;
  logic clk, rst_n, rx, tx, baud_high, jumper, ion_act, met, sp_lvl;
  logic [15:0] ctrl;
  gscc_press_t press;
  int fails, total_checks, cycles;
  gscc_top u_gscc_top (.sys_clk_in(clk), .rst_n_in(rst_n), .rx_in(rx), .tx_out(tx),
    .baud_high_in(baud_high), .setpoint_jumper_one_in(jumper), .external_control_on_in(1'b0),
    .ion_branch_active_in(ion_act), .ion_error_in(1'b0), .setpoint_pressure_met_in(met),
    .pressure_in(press), .gauge_control_out(ctrl), .setpoint_output_level_out(sp_lvl));
  gscc_host_model u_gscc_host_model (.sys_clk_in(clk), .baud_high_in(baud_high),
    .line_from_dev_in(tx), .line_to_dev_out(rx));
  // ---------------------
  // clock and hang guard
  // ---------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // frames are over 50000 cycles long and the run nears 2 million, so the ceiling sits only about a quarter above it
  always @(posedge clk) begin
    cycles++;
    if (cycles > 2500000) begin
      fails++;
      summarize();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] take();
    return u_gscc_host_model.rxq.size() > 0 ? u_gscc_host_model.rxq.pop_front() : 8'hff;
  endfunction
  task automatic expect_reply(input string s);
    int n;
    n = 0;
    while (u_gscc_host_model.rxq.size() < s.len() + 1 && n < (s.len() + 2) * 11 * `GSCC_DIV_HI)
    begin
      @(posedge clk);
      n++;
    end
    for (int i = 0; i < s.len(); i++) check({8'h00, take()}, {8'h00, s[i]});
    check({8'h00, take()}, 16'h000d);
  endtask
  // -------------
  // main sequence
  // -------------
  initial begin
    int n;
    rst_n = 1'b0;
    baud_high = 1'b1;
    jumper = 1'b0;
    ion_act = 1'b1;
    met = 1'b0;
    press = '{8'h35, 8'h33, 8'h30, 1'b0, 8'h30, 8'h31};
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    u_gscc_host_model.send_line("RS");
    expect_reply("001D");
    $display("test status read done");
    @(negedge clk);
    jumper = 1'b1;
    ion_act = 1'b0;
    u_gscc_host_model.send_line("SC_04a1");
    n = 0;
    while (ctrl !== 16'h04a1 && n < 4 * `GSCC_DIV_HI) begin
      @(negedge clk);
      n++;
    end
    check(ctrl, 16'h04a1);
    repeat (20) @(negedge clk);
    check({15'h0, tx}, 16'h0001);
    met = 1'b1;
    repeat (8) @(negedge clk);
    check({15'h0, sp_lvl}, 16'h0001);
    met = 1'b0;
    repeat (8) @(negedge clk);
    check({15'h0, sp_lvl}, 16'h0000);
    $display("test control write done");
    u_gscc_host_model.send_line("RV");
    expect_reply("P_5.30E+01");
    $display("test pressure read done");
    u_gscc_host_model.send_line("SC_0301");
    repeat (8) @(negedge clk);
    check(ctrl, 16'h0301);
    check({15'h0, sp_lvl}, 16'h0001);
    $display("test manual set-point done");
    summarize();
  end
endmodule // gscc_top_tb
`default_nettype wire
